// *** design/tsi_consts.vh ***
// constants for the terminal status and init pin block
// assumes inclusion by bare name from the design file
`ifndef TSI_CONSTS_VH
`define TSI_CONSTS_VH
`define TSI_TTSEL_EXT 3'h1
`define TSI_BOOT_WAIT 2'h2
`define TSI_TT_INT_DIV 6'h13
`define TSI_SCK_DIV 4'h4
`define TSI_SPI_READ 8'h03
`define TSI_ADDR_FULL 16'h7fff
`define TSI_ADDR_1K 16'h03ff
`define TSI_HDR_BITS 6'h20
`define TSI_WORD_BITS 6'h10
`define TSI_SELFTEST_LEN 16'h8000
`define TSI_ZERO16 16'h0000
`endif

// *** design/tsi_pins.v ***
// terminal status pins, time-tag clock select, auto-init spi master
// assumes one clock; protocol engine supplies busy/done levels
// Function
// - ready low during init or test
// - run only after start-execution bit set
// - active high while valid command processed
// - active falls at message completion
// - select 001 counts external time-tag clock
// - subsystem-fail input sets status flag
// - device is spi master to eeprom
// - init spi port has own pins
// - test input starts ram self-test
// - all timing from one master clock
// - auto-init enable at reset copies eeprom unless test input is also set
// - range select limits load span
`timescale 1ns/1ns
`include "tsi_consts.vh"
module tsi_pins (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // straps and pins from outside
    input wire auto_init_enable_in,
    input wire init_range_select_in,
    input wire test_enable_in,
    input wire subsystem_fail_in,
    input wire timetag_ext_clock_in,
    // configuration from host logic
    input wire start_execution_bit,
    input wire [2:0] timetag_clock_select,
    // protocol engine
    input wire cmd_valid_busy,
    input wire msg_done,
    // status outputs
    output reg ready,
    output reg active,
    output reg terminal_run,
    output reg subsystem_flag_bit,
    output reg [15:0] timetag_count,
    // loaded data toward ram and registers
    output reg load_we,
    output reg [15:0] load_addr,
    output reg [15:0] load_data,
    // dedicated init spi port
    output reg init_port_chip_select,
    output reg init_port_serial_clock,
    output reg mosi,
    input wire miso
);
    ////////////////////////////////////////////////////////////////////////
    // synchronisers for every pin input
    reg [5:0] sync1;  // first stage, only read by sync2
    reg [5:0] sync2;  // second stage, safe to use
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= {miso, timetag_ext_clock_in, subsystem_fail_in,
                      test_enable_in, init_range_select_in, auto_init_enable_in};
            sync2 <= sync1;
        end
    end
    wire s_auto = sync2[0];
    wire s_range = sync2[1];
    wire s_test = sync2[2];
    wire s_ssf = sync2[3];
    wire s_ttck = sync2[4];
    wire s_miso = sync2[5];

    ////////////////////////////////////////////////////////////////////////
    // sequencer states, one-hot
    localparam ST_BOOT = 5'h01;  // after release, held until synced straps are valid
    localparam ST_INIT = 5'h02;  // eeprom copy
    localparam ST_TEST = 5'h04;  // ram self-test
    localparam ST_IDLE = 5'h08;  // ready, waiting for start
    localparam ST_RUN = 5'h10;   // terminal executing
    reg [4:0] state;
    reg [4:0] next_state;
    reg [1:0] boot_wait;  // clocks spent letting straps cross the synchroniser
    reg spi_busy;         // spi engine transferring
    reg spi_start;        // one-cycle start for spi engine
    reg [15:0] test_cnt;  // self-test address walk
    reg [3:0] sck_div;    // serial clock divider
    reg [5:0] bit_cnt;    // bits left in phase
    reg hdr_phase;        // sending read command and address
    reg [31:0] shift_out; // command then address
    reg [15:0] shift_in;  // word being received
    reg [15:0] end_addr;  // last address to load
    reg word_done;        // one word landed

    // next state, test wins when both requested at boot
    always @* begin
        next_state = state;
        case (state)
            ST_BOOT: begin
                if (boot_wait != `TSI_BOOT_WAIT)
                    next_state = ST_BOOT; // straps not yet through sync
                else if (s_test)
                    next_state = ST_TEST;
                else if (s_auto)
                    next_state = ST_INIT;
                else
                    next_state = ST_IDLE;
            end
            ST_INIT: begin
                if (!spi_busy && !spi_start && word_done && load_addr == end_addr)
                    next_state = ST_IDLE;
            end
            ST_TEST: begin
                if (test_cnt == `TSI_SELFTEST_LEN - 16'h0001)
                    next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (s_test)
                    next_state = ST_TEST;
                else if (start_execution_bit)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (s_test)
                    next_state = ST_TEST;
            end
            default: next_state = ST_BOOT;
        endcase
    end

    // state register; ready is low from reset until work finishes
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_BOOT;
            ready <= 1'b0;
            terminal_run <= 1'b0;
            test_cnt <= `TSI_ZERO16;
            boot_wait <= 2'h0;
            end_addr <= `TSI_ADDR_FULL;
        end else begin
            state <= next_state;
            // ready only outside init and test
            ready <= (next_state == ST_IDLE) || (next_state == ST_RUN);
            terminal_run <= (next_state == ST_RUN);
            // synchroniser resets to zero, so straps are only valid once it refills
            if (state == ST_BOOT) begin
                if (boot_wait != `TSI_BOOT_WAIT)
                    boot_wait <= boot_wait + 2'h1;
                else
                    end_addr <= s_range ? `TSI_ADDR_1K : `TSI_ADDR_FULL;
            end
            if (state == ST_TEST)
                test_cnt <= test_cnt + 16'h0001;
            else
                test_cnt <= `TSI_ZERO16;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // active and subsystem flag outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active <= 1'b0;
            subsystem_flag_bit <= 1'b0;
        end else begin
            // completion drops active in the same edge it is seen
            active <= terminal_run && cmd_valid_busy && !msg_done;
            subsystem_flag_bit <= s_ssf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time-tag counter, external edge or internal tick, one clock
    reg tt_prev;       // previous external level
    reg [5:0] tt_div;  // internal tick divider
    wire tt_ext_sel = (timetag_clock_select == `TSI_TTSEL_EXT);
    wire tt_tick = tt_ext_sel ? (s_ttck && !tt_prev) : (tt_div == `TSI_TT_INT_DIV);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tt_prev <= 1'b0;
            tt_div <= 6'h00;
            timetag_count <= `TSI_ZERO16;
        end else begin
            tt_prev <= s_ttck;
            tt_div <= (tt_div == `TSI_TT_INT_DIV) ? 6'h00 : tt_div + 6'h01;
            if (tt_tick)
                timetag_count <= timetag_count + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // init spi master: one sequential read, mode 0, own pins
    // a single long read keeps eeprom overhead to one header
    wire sck_edge = (sck_div == `TSI_SCK_DIV);
    // read command, then a zero start address
    wire [31:0] hdr_word = {`TSI_SPI_READ, 8'h00, `TSI_ZERO16};
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spi_start <= 1'b0;
            spi_busy <= 1'b0;
            sck_div <= 4'h0;
            bit_cnt <= 6'h00;
            hdr_phase <= 1'b0;
            shift_out <= 32'h0000_0000;
            shift_in <= `TSI_ZERO16;
            init_port_chip_select <= 1'b1;
            init_port_serial_clock <= 1'b0;
            mosi <= 1'b0;
            load_we <= 1'b0;
            load_addr <= `TSI_ZERO16;
            load_data <= `TSI_ZERO16;
            word_done <= 1'b0;
        end else begin
            load_we <= 1'b0;
            spi_start <= (state == ST_BOOT) && (next_state == ST_INIT);
            if (spi_start) begin
                spi_busy <= 1'b1;
                init_port_chip_select <= 1'b0;
                hdr_phase <= 1'b1;
                bit_cnt <= `TSI_HDR_BITS;
                shift_out <= hdr_word;
                mosi <= hdr_word[31]; // first header bit ready before first rise
                sck_div <= 4'h0;
                load_addr <= `TSI_ZERO16;
                word_done <= 1'b0;
            end else if (spi_busy) begin
                sck_div <= sck_edge ? 4'h0 : sck_div + 4'h1;
                if (sck_edge && !init_port_serial_clock) begin
                    // rising: drive already set, sample input
                    init_port_serial_clock <= 1'b1;
                    if (!hdr_phase)
                        shift_in <= {shift_in[14:0], s_miso};
                end else if (sck_edge) begin
                    // falling: advance bit
                    init_port_serial_clock <= 1'b0;
                    if (bit_cnt == 6'h01) begin
                        bit_cnt <= `TSI_WORD_BITS;
                        mosi <= 1'b0;
                        if (hdr_phase) begin
                            hdr_phase <= 1'b0;
                        end else begin
                            load_we <= 1'b1;
                            load_data <= shift_in;
                            if (word_done)
                                load_addr <= load_addr + 16'h0001;
                            word_done <= 1'b1;
                            if (word_done ? (load_addr + 16'h0001 == end_addr)
                                          : (end_addr == `TSI_ZERO16)) begin
                                spi_busy <= 1'b0;
                                init_port_chip_select <= 1'b1;
                            end
                        end
                    end else begin
                        bit_cnt <= bit_cnt - 6'h01;
                        mosi <= shift_out[30];
                        shift_out <= {shift_out[30:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule

// *** testbench/tsi_pins_chk.sv ***
// concurrent checks on the status and init pin block ports
// assumes bind from the testbench top; single clk domain
`timescale 1ns/1ns
module tsi_pins_chk (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // watched inputs
    input wire test_enable_in,
    input wire subsystem_fail_in,
    input wire timetag_ext_clock_in,
    input wire start_execution_bit,
    input wire [2:0] timetag_clock_select,
    input wire cmd_valid_busy,
    input wire msg_done,
    // watched outputs
    input wire ready,
    input wire active,
    input wire terminal_run,
    input wire subsystem_flag_bit,
    input wire [15:0] timetag_count,
    input wire load_we,
    input wire [15:0] load_addr,
    input wire init_port_chip_select,
    input wire init_port_serial_clock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////
    // ready against init and test activity
    chk_ready_cs_low: assert property (!init_port_chip_select |-> !ready)
        else $error("ready high while init port selected");
    chk_test_holds_ready: assert property (test_enable_in [*5] |-> !ready)
        else $error("ready high during self-test");
    // run starts only from a ready device with start bit
    chk_run_needs_start: assert property ($rose(terminal_run) |->
        $past(start_execution_bit) && $past(ready))
        else $error("run began without start bit");
    // active follows a valid command, one clock late
    chk_active_cause: assert property (active ==
        $past(terminal_run && cmd_valid_busy && !msg_done))
        else $error("active does not follow command processing");
    chk_active_end_msg: assert property (active && msg_done |=> !active)
        else $error("active stayed high past message end");
    // subsystem flag tracks the synced input level
    chk_subsystem_flag_bit_follow: assert property (subsystem_fail_in [*5] |-> subsystem_flag_bit)
        else $error("subsystem flag not set");
    // external time-tag clock quiet means a frozen count
    chk_tt_ext_quiet: assert property ((timetag_clock_select == 3'h1 &&
        !timetag_ext_clock_in) [*6] |-> $stable(timetag_count))
        else $error("time-tag moved with quiet external clock");
    // init spi: clock only while selected, loads stay in span
    chk_sck_needs_cs: assert property (init_port_serial_clock |-> !init_port_chip_select)
        else $error("serial clock toggles while deselected");
    chk_load_span: assert property (load_we |-> !ready && load_addr <= 16'h7fff)
        else $error("load outside init span");
endmodule

// *** testbench/tsi_eeprom_model.sv ***
// serial eeprom behaving as spi slave on the dedicated init port
// assumes read header of 32 clocks, word k returns k plus 16'h1234
`timescale 1ns/1ns
module tsi_eeprom_model (
    // clock and spi lines from the master
    input wire clk,
    input wire cs_n,
    input wire sck,
    input wire mosi,
    // data back to the master, header bits seen for the bench
    output reg miso,
    output reg [31:0] hdr
);
    reg [31:0] cnt; // falls of sck seen so far in this frame
    reg sck_d; // previous sck for edge detect
    wire [31:0] d = cnt - 32'h0000_001f; // data bit index for this fall
    wire [15:0] w = d[19:4] + 16'h1234; // word being shifted out
    initial miso = 1'b0;
    ////////////////////////////////////////////////////////////////////
    // shift on sck fall so data is settled long before the next rise
    always @(posedge clk) begin
        sck_d <= sck;
        if (cs_n) begin
            cnt <= 32'h0000_0000;
            hdr <= 32'h0000_0000;
            miso <= 1'b0; // released line sits at its pull-down
        end else if (sck_d && !sck) begin
            cnt <= cnt + 32'h0000_0001;
            if (cnt >= 32'h0000_001f) miso <= w[4'hf - d[3:0]];
        end else if (!sck_d && sck && cnt < 32'h0000_0020) begin
            hdr <= {hdr[30:0], mosi};
        end
    end
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the terminal status and init pin block
// assumes design tsi_pins, checker and eeprom model compiled first
`timescale 1ns/1ns
module testbench;
    reg clk = 1'b0, rst_b = 1'b0, auto_init_enable_in = 1'b0, init_range_select_in = 1'b0;
    reg test_enable_in = 1'b0, subsystem_fail_in = 1'b0, timetag_ext_clock_in = 1'b0;
    reg start_execution_bit = 1'b0, cmd_valid_busy = 1'b0, msg_done = 1'b0;
    reg [2:0] timetag_clock_select = 3'h0;
    wire ready, active, terminal_run, subsystem_flag_bit, load_we, mosi, miso;
    wire init_port_chip_select, init_port_serial_clock;
    wire [15:0] timetag_count, load_addr, load_data;
    wire [31:0] eeprom_hdr;
    integer err_total = 0, check_count = 0, cyc = 0, w;
    reg [15:0] snap, n;
    tsi_pins dut (.clk, .rst_b, .auto_init_enable_in, .init_range_select_in, .test_enable_in,
        .subsystem_fail_in, .timetag_ext_clock_in, .start_execution_bit, .timetag_clock_select,
        .cmd_valid_busy, .msg_done, .ready, .active, .terminal_run, .subsystem_flag_bit,
        .timetag_count, .load_we, .load_addr, .load_data, .init_port_chip_select,
        .init_port_serial_clock, .mosi, .miso);
    tsi_eeprom_model u_mem (.clk, .cs_n(init_port_chip_select),
        .sck(init_port_serial_clock), .mosi, .miso, .hdr(eeprom_hdr));
    ////////////////////////////////////////////////////////////////////
    // single master clock, 50 ns period, and a hang guard
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            err_total = err_total + 1;
            report_and_stop;
        end
    end
    // comparison and helpers
    task check(input [15:0] seen, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task go(input integer c);
        repeat (c) @(negedge clk);
    endtask
    // straps held through the whole reset so they are stable at release
    task boot(input ae, input rs, input te);
        begin
            @(negedge clk);
            rst_b = 1'b0;
            start_execution_bit = 1'b0; // host config is cleared by reset
            auto_init_enable_in = ae;
            init_range_select_in = rs;
            test_enable_in = te;
            go(16);
            rst_b = 1'b1;
        end
    endtask
    task wait_ready(input integer lim);
        for (w = 0; w < lim && ready !== 1'b1; w = w + 1) go(1);
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        boot(1'b0, 1'b0, 1'b0);
        wait_ready(10);
        check(ready, 16'h0001);
        check(terminal_run, 16'h0000);
        start_execution_bit = 1'b1; // host touches config only once ready
        go(2);
        check(terminal_run, 16'h0001);
        cmd_valid_busy = 1'b1;
        go(2);
        check(active, 16'h0001);
        msg_done = 1'b1;
        go(1);
        check(active, 16'h0000);
        msg_done = 1'b0;
        cmd_valid_busy = 1'b0;
        subsystem_fail_in = 1'b1;
        go(6);
        check(subsystem_flag_bit, 16'h0001);
        subsystem_fail_in = 1'b0;
        go(6);
        check(subsystem_flag_bit, 16'h0000);
        $display("test run and status pins done");
        // internal tick every 20 clk, then external edges only
        snap = timetag_count;
        go(200);
        check(timetag_count - snap, 16'h000a);
        timetag_clock_select = 3'h1;
        go(8);
        snap = timetag_count;
        repeat (7) begin
            timetag_ext_clock_in = 1'b1;
            go(3);
            timetag_ext_clock_in = 1'b0;
            go(3);
        end
        go(6);
        check(timetag_count - snap, 16'h0007);
        // other select values keep the internal tick and ignore the pin
        timetag_clock_select = 3'h2;
        snap = timetag_count;
        repeat (20) begin
            timetag_ext_clock_in = 1'b1;
            go(5);
            timetag_ext_clock_in = 1'b0;
            go(5);
        end
        check(timetag_count - snap, 16'h000a);
        $display("test time-tag done");
        // self-test holds ready low for its full walk
        boot(1'b0, 1'b0, 1'b1);
        go(20);
        check(ready, 16'h0000);
        test_enable_in = 1'b0;
        wait_ready(33000);
        check(ready, 16'h0001);
        check(terminal_run, 16'h0000);
        $display("test self-test done");
        // auto-init: first words land at ascending addresses
        boot(1'b1, 1'b0, 1'b0);
        go(6);
        check(ready, 16'h0000);
        check(init_port_chip_select, 16'h0000);
        for (n = 16'h0000; n < 16'h0003; n = n + 16'h0001) begin
            for (w = 0; w < 1000 && load_we !== 1'b1; w = w + 1) go(1);
            check(load_addr, n);
            check(load_data, n + 16'h1234);
            go(1);
        end
        check(eeprom_hdr[31:16], 16'h0300);
        check(eeprom_hdr[15:0], 16'h0000);
        $display("test auto-init done");
        report_and_stop;
    end
endmodule
bind tsi_pins tsi_pins_chk u_chk (.*);
